//--- src/mrb_defines.vh
// Purpose: Shared constants of the measurement register bank.
// Assumes: Included by bare name from every design file of the bank.
// Notes:   Offsets are byte addresses on the 32-bit register bus.
`ifndef MRB_DEFINES_VH
`define MRB_DEFINES_VH

// ****************************************
// Register map
// ****************************************
`define MRB_OFS_CMD     8'h00
`define MRB_OFS_DIGEST  8'h04
`define MRB_OFS_STATUS  8'h08
`define MRB_OFS_RESULT  8'h0c
`define MRB_OFS_BANKS   8'h10

// ****************************************
// Command word fields
// ****************************************
`define MRB_F_OP_HI     3
`define MRB_F_OP_LO     0
`define MRB_F_IDX_HI    8
`define MRB_F_IDX_LO    4
`define MRB_F_LOC_HI    14
`define MRB_F_LOC_LO    12
`define MRB_F_BANK      15
`define MRB_F_MASK_HI   17
`define MRB_F_MASK_LO   16

// ****************************************
// Command codes
// ****************************************
`define MRB_OP_CLEAR    4'h1
`define MRB_OP_FOLD     4'h2
`define MRB_OP_EVENT    4'h3
`define MRB_OP_ALLOC    4'h4
`define MRB_OP_CAPQ     4'h5
`define MRB_OP_SETPOL   4'h6
`define MRB_OP_SETAUTH  4'h7
`define MRB_OP_STARTUP  4'h8
`define MRB_OP_LAUNCH   4'h9
`define MRB_OP_READ     4'ha

// ****************************************
// Response codes and reset values
// ****************************************
`define MRB_RC_OK        8'h00
`define MRB_RC_BADVALUE  8'h01
`define MRB_RC_NORESULT  8'h02
`define MRB_RC_REFUSED   8'h03
`define MRB_RC_BADCMD    8'h04
`define MRB_ALG_SHA256   16'h000b
`define MRB_ALG_SHA1     16'h0004
`define MRB_BANKS_RESET  2'h3
`define MRB_LOC_TOP      3'h4
`define MRB_IDX_BOOT     5'h00
`define MRB_IDX_LAUNCH   5'h11
`define MRB_LAUNCH_LO    17
`define MRB_LAUNCH_HI    22
`define MRB_SAVE_HI      15

`endif

//--- src/mrb_policy.v
// Purpose: Fixed per-register permission maps and attributes.
// Assumes: Index below the register count; locality in 0..4.
// Notes:   Masks are ordered locality 4 down to 0, bit 4 = locality 4.
`timescale 1ns/1ps
`include "mrb_defines.vh"
module mrb_policy (
   idx,
   loc,
   clearOk,
   foldOk,
   launchOk,
   resetInd,
   saveFlag,
   noIncFlag
);
   input  wire [4:0] idx;
   input  wire [2:0] loc;
   output wire       clearOk;
   output wire       foldOk;
   output wire       launchOk;
   output reg  [4:0] resetInd;
   output wire       saveFlag;
   output wire       noIncFlag;

   reg [4:0] clrMap;
   reg [4:0] foldMap;
   reg [4:0] dlMap;
   wire      locOk = (loc <= `MRB_LOC_TOP);

   always @* begin
      clrMap   = 5'h00;
      dlMap    = 5'h00;
      foldMap  = 5'h1f;
      resetInd = 5'h00;
      case (idx)
         5'd16, 5'd23: begin
            clrMap   = 5'h0f;
            resetInd = 5'h0f;
         end
         5'd17, 5'd18: begin
            dlMap    = 5'h10;
            foldMap  = 5'h1c;
            resetInd = 5'h10;
         end
         5'd19: begin
            dlMap    = 5'h10;
            foldMap  = 5'h0c;
            resetInd = 5'h10;
         end
         5'd20: begin
            clrMap   = 5'h0c;
            dlMap    = 5'h10;
            foldMap  = 5'h0e;
            resetInd = 5'h1c;
         end
         5'd21, 5'd22: begin
            clrMap   = 5'h0c;
            dlMap    = 5'h10;
            foldMap  = 5'h04;
            resetInd = 5'h1c;
         end
         default: begin
            clrMap   = 5'h00;
         end
      endcase
   end

   assign clearOk   = locOk & clrMap[loc];
   assign foldOk    = locOk & foldMap[loc];
   assign launchOk  = locOk & dlMap[loc];
   assign saveFlag  = (idx <= `MRB_SAVE_HI);
   assign noIncFlag = (idx == 5'd16) | (idx >= 5'd21);
endmodule // mrb_policy

//--- src/mrb_fold.v
// Purpose: Folds a supplied digest into a register value for one bank.
// Assumes: Combinational; result is captured by the caller.
// Notes:   A compact mixing stand-in; a full digest engine replaces it.
`timescale 1ns/1ps
`include "mrb_defines.vh"
module mrb_fold #(
   parameter DW = 32
) (
   oldVal,
   digest,
   algId,
   newVal
);
   input  wire [DW-1:0] oldVal;
   input  wire [DW-1:0] digest;
   input  wire [15:0]   algId;
   output wire [DW-1:0] newVal;

   wire [DW-1:0] rot  = {oldVal[DW-6:0], oldVal[DW-1:DW-5]};
   wire [DW-1:0] salt = {{(DW-16){1'b0}}, algId};
   wire [DW-1:0] mix  = (rot ^ digest) + salt;

   // value depends on old contents then digest.
   assign newVal = {mix[DW-8:0], mix[DW-1:DW-7]} ^ oldVal;
endmodule // mrb_fold

//--- src/mrb_top.v
// Purpose: Measurement register bank with locality permission checks.
// Assumes: Single clock; commands issued through the register bus.
// Notes:   Every command completes in the cycle its command word lands.
`timescale 1ns/1ps
`include "mrb_defines.vh"

module mrb_top #(
   parameter NREG  = 24,
   parameter DW    = 32,
   parameter NBANK = 2
) (
   clk,
   rst_b,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input  wire        clk;
   input  wire        rst_b;
   input  wire [7:0]  s_axi_awaddr;
   input  wire        s_axi_awvalid;
   output wire        s_axi_awready;
   input  wire [31:0] s_axi_wdata;
   input  wire [3:0]  s_axi_wstrb;
   input  wire        s_axi_wvalid;
   output wire        s_axi_wready;
   output reg  [1:0]  s_axi_bresp;
   output reg         s_axi_bvalid;
   input  wire        s_axi_bready;
   input  wire [7:0]  s_axi_araddr;
   input  wire        s_axi_arvalid;
   output wire        s_axi_arready;
   output reg  [31:0] s_axi_rdata;
   output reg  [1:0]  s_axi_rresp;
   output reg         s_axi_rvalid;
   input  wire        s_axi_rready;

   // ****************************************
   // Write channel capture
   // ****************************************
   reg        awHeld_r;
   reg        wHeld_r;
   reg [7:0]  awAddr_r;
   reg [31:0] wData_r;
   reg [3:0]  wStrb_r;

   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;

   wire        awFire  = s_axi_awvalid & s_axi_awready;
   wire        wFire   = s_axi_wvalid & s_axi_wready;
   wire        doWrite = (awHeld_r | awFire) & (wHeld_r | wFire);
   wire [7:0]  wrAddr  = awHeld_r ? awAddr_r : s_axi_awaddr;
   wire [31:0] wrData  = wHeld_r ? wData_r : s_axi_wdata;
   wire [3:0]  wrStrb  = wHeld_r ? wStrb_r : s_axi_wstrb;
   wire        wrMap   = (wrAddr == `MRB_OFS_CMD) |
                         (wrAddr == `MRB_OFS_DIGEST);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         awHeld_r     <= 1'b0;
         wHeld_r      <= 1'b0;
         awAddr_r     <= 8'h00;
         wData_r      <= 32'h00000000;
         wStrb_r      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (doWrite) begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrMap ? 2'h0 : 2'h2;
         end else begin
            if (awFire) begin
               awHeld_r <= 1'b1;
               awAddr_r <= s_axi_awaddr;
            end
            if (wFire) begin
               wHeld_r <= 1'b1;
               wData_r <= s_axi_wdata;
               wStrb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   reg [DW-1:0]    digest_r;
   reg [NBANK-1:0] bankEn_r;
   reg [7:0]       resp_r;
   reg [31:0]      result_r;
   reg [7:0]       cmdCount_r;
   reg [DW-1:0]    mem_r [0:NBANK*NREG-1];

   wire        cmdGo   = doWrite & (wrAddr == `MRB_OFS_CMD);
   wire [3:0]  op      = wrData[`MRB_F_OP_HI:`MRB_F_OP_LO];
   wire [4:0]  idx     = wrData[`MRB_F_IDX_HI:`MRB_F_IDX_LO];
   wire [2:0]  loc     = wrData[`MRB_F_LOC_HI:`MRB_F_LOC_LO];
   wire        bankSel = wrData[`MRB_F_BANK];
   wire [1:0]  reqMask = wrData[`MRB_F_MASK_HI:`MRB_F_MASK_LO];
   wire        idxOk   = ({27'h0, idx} < NREG);
   wire        locOk   = (loc <= `MRB_LOC_TOP);

   wire       clearOk;
   wire       foldOk;
   wire [4:0] resetInd;
   wire       saveFlag;
   wire       noIncFlag;

   // The launch map is not needed here: a launch always spans 17..22.
   mrb_policy mrb_policy_inst (
      .idx       (idx),
      .loc       (loc),
      .clearOk   (clearOk),
      .foldOk    (foldOk),
      .launchOk  (),
      .resetInd  (resetInd),
      .saveFlag  (saveFlag),
      .noIncFlag (noIncFlag)
   );

   // fixed hash identifier per bank; bank 0 is the default.
   wire [15:0] algOf [0:1];
   assign algOf[0] = `MRB_ALG_SHA256;
   assign algOf[1] = `MRB_ALG_SHA1;

   wire [DW-1:0] foldVal [0:NBANK-1];
   wire [DW-1:0] readVal = mem_r[bankSel * NREG + idx];
   genvar g;
   generate
      for (g = 0; g < NBANK; g = g + 1) begin : gBank
         mrb_fold #(.DW(DW)) mrb_fold_inst (
            .oldVal (mem_r[g * NREG + idx]),
            .digest (digest_r),
            .algId  (algOf[g]),
            .newVal (foldVal[g])
         );
      end
   endgenerate

   // Byte strobes merge the staged digest so it can be written in parts.
   wire [31:0] strbMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}},
                           {8{wrStrb[1]}}, {8{wrStrb[0]}}};
   wire [31:0] digMerge = (wrData & strbMask) |
                          (digest_r[31:0] & ~strbMask);

   // ****************************************
   // Command execution and register storage
   // ****************************************
   integer b;
   integer i;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         digest_r   <= {DW{1'b0}};
         // both mandatory banks enabled out of reset.
         bankEn_r   <= `MRB_BANKS_RESET;
         resp_r     <= `MRB_RC_OK;
         result_r   <= 32'h00000000;
         cmdCount_r <= 8'h00;
         for (b = 0; b < NBANK; b = b + 1) begin
            for (i = 0; i < NREG; i = i + 1) begin
               if (i >= `MRB_LAUNCH_LO && i <= `MRB_LAUNCH_HI) begin
                  mem_r[b * NREG + i] <= {DW{1'b1}};
               end else begin
                  mem_r[b * NREG + i] <= {DW{1'b0}};
               end
            end
         end
      end else begin
         if (doWrite && wrAddr == `MRB_OFS_DIGEST) begin
            digest_r[31:0] <= digMerge;
         end
         if (cmdGo) begin
            cmdCount_r <= cmdCount_r + 8'h01;
            // each refusal below stores only a code.
            case (op)
               `MRB_OP_CLEAR: begin
                  if (!idxOk || !locOk) begin
                     resp_r <= `MRB_RC_BADVALUE;
                  end else if (!clearOk) begin
                     resp_r <= `MRB_RC_REFUSED;
                  end else begin
                     resp_r <= `MRB_RC_OK;
                     for (b = 0; b < NBANK; b = b + 1) begin
                        mem_r[b * NREG + idx] <= {DW{1'b0}};
                     end
                  end
               end
               `MRB_OP_FOLD, `MRB_OP_EVENT: begin
                  if (!idxOk || !locOk) begin
                     resp_r <= `MRB_RC_BADVALUE;
                  // locality gate for fold and event.
                  end else if (!foldOk) begin
                     resp_r <= `MRB_RC_REFUSED;
                  end else begin
                     resp_r <= `MRB_RC_OK;
                     for (b = 0; b < NBANK; b = b + 1) begin
                        if (bankEn_r[b]) begin
                           mem_r[b * NREG + idx] <= foldVal[b];
                        end
                     end
                  end
               end
               `MRB_OP_ALLOC: begin
                  // only the full 0..23 set is accepted.
                  if (reqMask == 2'h0) begin
                     resp_r <= `MRB_RC_BADVALUE;
                  end else if ({27'h0, idx} != NREG - 1) begin
                     resp_r <= `MRB_RC_NORESULT;
                  end else begin
                     resp_r   <= `MRB_RC_OK;
                     bankEn_r <= reqMask[NBANK-1:0];
                  end
               end
               `MRB_OP_CAPQ: begin
                  if (!idxOk) begin
                     resp_r <= `MRB_RC_BADVALUE;
                  end else begin
                     resp_r   <= `MRB_RC_OK;
                     // auth and policy flags stay clear.
                     result_r <= {20'h00000, saveFlag, 1'b0, 1'b0,
                                  noIncFlag, 3'h0, resetInd};
                  end
               end
               `MRB_OP_SETPOL, `MRB_OP_SETAUTH: begin
                  resp_r <= `MRB_RC_BADVALUE;
               end
               `MRB_OP_STARTUP: begin
                  if (!locOk) begin
                     resp_r <= `MRB_RC_BADVALUE;
                  end else begin
                     resp_r <= `MRB_RC_OK;
                     for (b = 0; b < NBANK; b = b + 1) begin
                        for (i = 0; i < NREG; i = i + 1) begin
                           if (i >= `MRB_LAUNCH_LO &&
                               i <= `MRB_LAUNCH_HI) begin
                              mem_r[b * NREG + i] <= {DW{1'b1}};
                           end else begin
                              mem_r[b * NREG + i] <= {DW{1'b0}};
                           end
                        end
                        // register 0 is the boot-trust register.
                        mem_r[b * NREG + `MRB_IDX_BOOT] <=
                           {{(DW-3){1'b0}}, loc};
                     end
                  end
               end
               `MRB_OP_LAUNCH: begin
                  resp_r <= locOk ? `MRB_RC_OK : `MRB_RC_BADVALUE;
                  // register 17 is the first of them.
                  if (loc == `MRB_LOC_TOP) begin
                     for (b = 0; b < NBANK; b = b + 1) begin
                        for (i = `MRB_LAUNCH_LO; i <= `MRB_LAUNCH_HI;
                             i = i + 1) begin
                           mem_r[b * NREG + i] <= {DW{1'b0}};
                        end
                     end
                  end
               end
               `MRB_OP_READ: begin
                  if (!idxOk || !bankEn_r[bankSel]) begin
                     resp_r <= `MRB_RC_BADVALUE;
                  end else begin
                     resp_r   <= `MRB_RC_OK;
                     result_r <= readVal[31:0];
                  end
               end
               default: begin
                  resp_r <= `MRB_RC_BADCMD;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   assign s_axi_arready = ~s_axi_rvalid;
   reg [31:0] rdMux;
   reg        rdMap;
   always @* begin
      rdMap = 1'b1;
      case (s_axi_araddr)
         `MRB_OFS_DIGEST: rdMux = digest_r[31:0];
         `MRB_OFS_STATUS: rdMux = {16'h0000, cmdCount_r, resp_r};
         `MRB_OFS_RESULT: rdMux = result_r;
         `MRB_OFS_BANKS:  rdMux = {30'h0, bankEn_r[1:0]};
         `MRB_OFS_CMD:    rdMux = 32'h00000000;
         default: begin
            rdMux = 32'h00000000;
            rdMap = 1'b0;
         end
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdMux;
         s_axi_rresp  <= rdMap ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // mrb_top

//--- tb/mrb_top_chk.sv
// Purpose: Bus timing checks on the measurement register bank.
// Assumes: One clock; rst_b is asynchronous and active low.
// Notes:   Bound to mrb_top; sees its bus ports only.
`timescale 1ns/1ps
module mrb_top_chk (
   input wire        clk,
   input wire        rst_b,
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer:
   assert property (wrTaken |=> s_axi_bvalid) else $error("no write answer");
   a_read_answer:
   assert property (rdTaken |=> s_axi_rvalid) else $error("no read answer");
   a_bresp_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
      $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read moved");
   a_answer_release:
   assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer stuck");
   a_write_block:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   a_read_block:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   a_write_unmapped:
   assert property (wrTaken and s_axi_awaddr > 8'h10 |=> s_axi_bresp == 2'h2)
      else $error("unmapped write accepted");
   a_read_unmapped:
   assert property (rdTaken and s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   a_cmd_reads_zero:
   assert property (rdTaken and s_axi_araddr == 8'h00 |=> s_axi_rdata == 32'h0)
      else $error("command word readable");
endmodule // mrb_top_chk

bind mrb_top mrb_top_chk mrb_top_chk_inst (.*);

//--- tb/mrb_host.sv
// Purpose: Host side bus master issuing register bus cycles.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   lag delays the response ready to exercise a slow host.
`timescale 1ns/1ps
module mrb_host (
   input  wire        clk,
   output reg  [7:0]  s_axi_awaddr,
   output reg         s_axi_awvalid,
   input  wire        s_axi_awready,
   output reg  [31:0] s_axi_wdata,
   output reg  [3:0]  s_axi_wstrb,
   output reg         s_axi_wvalid,
   input  wire        s_axi_wready,
   input  wire [1:0]  s_axi_bresp,
   input  wire        s_axi_bvalid,
   output reg         s_axi_bready,
   output reg  [7:0]  s_axi_araddr,
   output reg         s_axi_arvalid,
   input  wire        s_axi_arready,
   input  wire [31:0] s_axi_rdata,
   input  wire [1:0]  s_axi_rresp,
   input  wire        s_axi_rvalid,
   output reg         s_axi_rready
);
   integer lag;
   reg     aw;
   reg     w;
   initial begin
      lag = 0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end
   // Each channel is dropped only at the edge that takes it.
   task wr(input [7:0] a, input [31:0] dat, output [1:0] rsp);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= dat;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         aw = 1'b1;
         w = 1'b1;
         while (aw || w) begin
            @(posedge clk);
            if (aw && s_axi_awready) begin
               aw = 1'b0;
               s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
               w = 1'b0;
               s_axi_wvalid <= 1'b0;
            end
         end
         repeat (lag) @(posedge clk);
         s_axi_bready <= 1'b1;
         do @(posedge clk); while (!s_axi_bvalid);
         rsp = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [31:0] dat, output [1:0] rsp);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         do @(posedge clk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         repeat (lag) @(posedge clk);
         s_axi_rready <= 1'b1;
         do @(posedge clk); while (!s_axi_rvalid);
         dat = s_axi_rdata;
         rsp = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
endmodule // mrb_host

//--- tb/mrb_top_tb.sv
// Purpose: Self-checking bench of the measurement register bank.
// Assumes: Commands go through the command word, codes via status, values via result.
// Notes:   Fold results are only checked for change; the mixer is opaque.
`timescale 1ns/1ps
`include "mrb_defines.vh"
module mrb_top_tb;
   reg         clk, rst_b, ok;
   reg  [31:0] d, e;
   reg  [1:0]  r;
   reg  [4:0]  m;
   reg  [3:0]  op;
   wire [7:0]  s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0]  s_axi_wstrb;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   wire        s_axi_rvalid, s_axi_rready;
   integer     failCount, numChecks, i, l, k;
   mrb_top mrb_top_inst (.*);
   mrb_host mrb_host_inst (.*);
   // ****************************************
   // Helpers
   // ****************************************
   task chk(input string nm, input [31:0] ex, input [31:0] got);
      begin
         numChecks = numChecks + 1;
         if (ex !== got) begin
            failCount = failCount + 1;
            $display("mismatch %0s exp %h got %h", nm, ex, got);
         end
      end
   endtask
   task cmd(input [3:0] o, input [4:0] ix, input [2:0] lc, input [2:0] bm,
            input [7:0] ec);
      begin
         mrb_host_inst.wr(`MRB_OFS_CMD, {14'h0, bm, lc, 3'h0, ix, o}, r);
         mrb_host_inst.rd(`MRB_OFS_STATUS, d, r);
         chk("code", {24'h0, ec}, {24'h0, d[7:0]});
      end
   endtask
   task rreg(input [4:0] ix, input b);
      begin
         cmd(`MRB_OP_READ, ix, 3'h0, {2'h0, b}, `MRB_RC_OK);
         mrb_host_inst.rd(`MRB_OFS_RESULT, d, r);
      end
   endtask
   task qbanks(input [31:0] ex);
      begin
         mrb_host_inst.rd(`MRB_OFS_BANKS, d, r);
         chk("banks", ex, d & 32'h3);
      end
   endtask
   // Value after a clearing startup received at locality 3.
   function [31:0] iv(input integer x);
      iv = (x == 0) ? 32'h3 : (x >= 17 && x <= 22) ? 32'hffffffff : 32'h0;
   endfunction
   function [4:0] rind(input integer x);
      rind = (x == 16 || x == 23) ? 5'h0f : (x >= 20 && x <= 22) ? 5'h1c :
             (x >= 17) ? 5'h10 : 5'h00;
   endfunction
   function fok(input integer x, input integer q);
      fok = (x <= 16 || x == 23) ? 1'b1 : (x <= 18) ? q >= 2 : (x == 19) ?
            (q == 2 || q == 3) : (x == 20) ? (q >= 1 && q <= 3) : q == 2;
   endfunction
   task closeOut;
      begin
         $display("checks %0d mismatches %0d", numChecks, failCount);
         if (failCount == 0 && numChecks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #2000000;
      failCount = failCount + 1;
      closeOut;
   end
   initial begin
      failCount = 0;
      numChecks = 0;
      rst_b = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      qbanks(32'h3);
      rreg(5'h11, 1'b1);
      chk("rst17", 32'hffffffff, d);
      rreg(5'h00, 1'b0);
      chk("rst0", 32'h0, d);
      // Clear, fold or event, and launch over every register and locality.
      for (k = 0; k < 3; k = k + 1)
         for (i = 0; i < 24; i = i + 1)
            for (l = 0; l < 5; l = l + 1) begin
               m = rind(i);
               ok = (k == 0) ? (l < 4 && m[l]) : (k == 1) ? fok(i, l) : 1'b1;
               op = (k == 0) ? `MRB_OP_CLEAR : (k == 2) ? `MRB_OP_LAUNCH :
                    (l % 2) ? `MRB_OP_EVENT : `MRB_OP_FOLD;
               cmd(`MRB_OP_STARTUP, 5'h0, 3'h3, 3'h0, `MRB_RC_OK);
               rreg(i[4:0], i[0]);
               chk("init", iv(i), d);
               mrb_host_inst.wr(`MRB_OFS_DIGEST, 32'h5a5a0100 + i, r);
               cmd(op, i[4:0], l[2:0], 3'h0,
                   ok ? `MRB_RC_OK : `MRB_RC_REFUSED);
               rreg(i[4:0], i[0]);
               e = (ok && (k == 0 || (l == 4 && i >= 17 && i <= 22))) ?
                   32'h0 : iv(i);
               if (k == 1 && ok)
                  chk("fold", 32'h1, {31'h0, d != e});
               else
                  chk("value", e, d);
            end
      mrb_host_inst.lag = 1;
      for (i = 0; i < 24; i = i + 1) begin
         cmd(`MRB_OP_CAPQ, i[4:0], 3'h0, 3'h0, `MRB_RC_OK);
         mrb_host_inst.rd(`MRB_OFS_RESULT, d, r);
         chk("caps", {20'h0, i < 16, 2'h0, i == 16 || i > 20, 3'h0, rind(i)},
             d & 32'h00000f1f);
      end
      cmd(`MRB_OP_SETPOL, 5'h0, 3'h0, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_SETAUTH, 5'h0, 3'h0, 3'h0, `MRB_RC_BADVALUE);
      cmd(4'hf, 5'h0, 3'h0, 3'h0, `MRB_RC_BADCMD);
      cmd(`MRB_OP_FOLD, 5'h18, 3'h0, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_FOLD, 5'h0, 3'h5, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_CLEAR, 5'h18, 3'h0, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_LAUNCH, 5'h0, 3'h7, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_STARTUP, 5'h0, 3'h5, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_CAPQ, 5'h18, 3'h0, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_ALLOC, 5'h17, 3'h0, 3'h0, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_ALLOC, 5'h16, 3'h0, 3'h2, `MRB_RC_NORESULT);
      qbanks(32'h3);
      cmd(`MRB_OP_ALLOC, 5'h17, 3'h0, 3'h2, `MRB_RC_OK);
      qbanks(32'h1);
      cmd(`MRB_OP_READ, 5'h0, 3'h0, 3'h1, `MRB_RC_BADVALUE);
      cmd(`MRB_OP_ALLOC, 5'h17, 3'h0, 3'h4, `MRB_RC_OK);
      qbanks(32'h2);
      cmd(`MRB_OP_ALLOC, 5'h17, 3'h0, 3'h6, `MRB_RC_OK);
      qbanks(32'h3);
      mrb_host_inst.wr(8'h40, 32'h1, r);
      chk("bresp", 32'h2, {30'h0, r});
      mrb_host_inst.rd(8'h40, d, r);
      chk("rresp", 32'h2, {30'h0, r});
      chk("rdata", 32'h0, d);
      mrb_host_inst.rd(`MRB_OFS_CMD, d, r);
      chk("cmdrd", 32'h0, d);
      closeOut;
   end
endmodule // mrb_top_tb
